/* File: design/alu_slice.sv */
// Accumulator, flags, small data memory and command register behind AXI4-Lite.
// Assumes one write and one read at most outstanding, single clock aclk.
//
// Overview of operation
// RULE_01: Add with carry into accumulator, update flags
// RULE_02: Add with carry into memory byte, flags
// RULE_03: Plain add memory into accumulator, update flags
// RULE_04: Add immediate into accumulator, update flags
// RULE_05: Plain add into memory byte, update flags
// RULE_06: AND memory into accumulator, zero only
// RULE_07: AND immediate into accumulator, zero only
// RULE_08: AND result written back to memory
// RULE_09: Zero, carry, aux carry, overflow definitions
// RULE_10: Unaffected flags and accumulator hold value
`timescale 1ns/1ns
module alu_slice
    import alu_pkg::*;
(
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Write address
    input wire logic awvalid,
    input wire logic [ADDR_W-1:0] awaddr,
    input wire logic [2:0] awprot,
    output logic awready,
    // Write data
    input wire logic wvalid,
    input wire logic [DATA_W-1:0] wdata,
    input wire logic [3:0] wstrb,
    output logic wready,
    // Write response
    output logic bvalid,
    output logic [1:0] bresp,
    input wire logic bready,
    // Read address
    input wire logic arvalid,
    input wire logic [ADDR_W-1:0] araddr,
    input wire logic [2:0] arprot,
    output logic arready,
    // Read data
    output logic rvalid,
    output logic [DATA_W-1:0] rdata,
    output logic [1:0] rresp,
    input wire logic rready
);

    // ****************************************
    // Address decode
    // ****************************************
    function automatic logic [2:0] region_of(input logic [ADDR_W-1:0] a);
        logic [7:0] w;
        w = {a[7:2], 2'b00};
        if (w == ACC_OFFSET) begin
            return REGION_ACC;
        end else if (w == STATUS_OFFSET) begin
            return REGION_STATUS;
        end else if (w == COMMAND_OFFSET) begin
            return REGION_COMMAND;
        end else if (w >= MEM_BASE && w <= MEM_LIMIT) begin
            return REGION_MEM;
        end else begin
            return REGION_NONE;
        end
    endfunction : region_of

    // ****************************************
    // State
    // ****************************************
    logic [7:0] accumulator_reg;
    flags_type flags;
    command_type command;
    logic [7:0] mem [MEM_DEPTH];
    wr_state_type wr_state;
    logic aw_full;
    logic w_full;
    logic [ADDR_W-1:0] wr_addr;
    logic [DATA_W-1:0] wr_data;
    logic [3:0] wr_strb;

    logic wr_go;
    logic [2:0] wr_region;
    logic cmd_go;
    command_type next_command;
    logic [7:0] alu_result;
    flags_type alu_flags;
    logic alu_to_acc;
    logic alu_to_mem;

    always_comb begin
        wr_go = aw_full && w_full && (wr_state == wr_collect);
        wr_region = region_of(wr_addr);
        cmd_go = wr_go && (wr_region == REGION_COMMAND) && wr_strb[0];
        next_command = command;
        if (wr_strb[0]) begin
            next_command.op = wr_data[3:0];
            next_command.addr = wr_data[7:4];
        end
        if (wr_strb[1]) begin
            next_command.imm = wr_data[15:8];
        end
    end

    alu_unit u_alu_unit (
        .op(cmd_go ? next_command.op : OP_NONE),
        .accumulator_reg(accumulator_reg),
        .mem_byte(mem[next_command.addr]),
        .imm(next_command.imm),
        .flags_in(flags),
        .result(alu_result),
        .flags_out(alu_flags),
        .to_acc(alu_to_acc),
        .to_mem(alu_to_mem)
    );

    // ****************************************
    // Accumulator
    // ****************************************
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            accumulator_reg <= ACC_RESET;
        end else if (alu_to_acc) begin
            accumulator_reg <= alu_result; // RULE_01 RULE_03 RULE_04 RULE_06 RULE_07
        end else if (wr_go && wr_region == REGION_ACC && wr_strb[0]) begin
            accumulator_reg <= wr_data[7:0];
        end
    end

    // ****************************************
    // Flags and command
    // ****************************************
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            flags <= FLAGS_RESET;
            command <= COMMAND_RESET;
        end else begin
            if (cmd_go) begin
                flags <= alu_flags; // RULE_09 RULE_10
                command <= next_command;
            end else if (wr_go && wr_region == REGION_STATUS && wr_strb[0]) begin
                flags <= wr_data[4:0];
            end
        end
    end

    // ****************************************
    // Data memory
    // ****************************************
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            for (int i = 0; i < MEM_DEPTH; i++) begin
                mem[i] <= MEM_RESET;
            end
        end else if (alu_to_mem) begin
            mem[next_command.addr] <= alu_result; // RULE_02 RULE_05 RULE_08
        end else if (wr_go && wr_region == REGION_MEM && wr_strb[0]) begin
            mem[wr_addr[5:2]] <= wr_data[7:0];
        end
    end

    // ****************************************
    // Write channel
    // ****************************************
    // Address and data are caught separately so either may arrive first
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            wr_state <= wr_collect;
            awready <= 1'b0;
            wready <= 1'b0;
            aw_full <= 1'b0;
            w_full <= 1'b0;
            wr_addr <= '0;
            wr_data <= '0;
            wr_strb <= '0;
            bvalid <= 1'b0;
            bresp <= RESP_OKAY;
        end else begin
            case (wr_state)
                wr_collect: begin
                    awready <= !aw_full && !(awvalid && awready);
                    wready <= !w_full && !(wvalid && wready);
                    if (awvalid && awready) begin
                        aw_full <= 1'b1;
                        wr_addr <= awaddr;
                    end
                    if (wvalid && wready) begin
                        w_full <= 1'b1;
                        wr_data <= wdata;
                        wr_strb <= wstrb;
                    end
                    if (wr_go) begin
                        bvalid <= 1'b1;
                        bresp <= (wr_region == REGION_NONE) ? RESP_SLVERR : RESP_OKAY;
                        wr_state <= wr_respond;
                    end
                end
                wr_respond: begin
                    if (bready) begin
                        bvalid <= 1'b0;
                        aw_full <= 1'b0;
                        w_full <= 1'b0;
                        wr_state <= wr_collect;
                    end
                end
                default: begin
                    wr_state <= wr_collect;
                end
            endcase
        end
    end

    // ****************************************
    // Read channel
    // ****************************************
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            arready <= 1'b0;
            rvalid <= 1'b0;
            rdata <= '0;
            rresp <= RESP_OKAY;
        end else if (rvalid) begin
            if (rready) begin
                rvalid <= 1'b0;
                arready <= 1'b1;
            end
        end else if (arvalid && arready) begin
            arready <= 1'b0;
            rvalid <= 1'b1;
            rresp <= RESP_OKAY;
            rdata <= '0;
            if (region_of(araddr) == REGION_ACC) begin
                rdata <= {24'h000000, accumulator_reg};
            end else if (region_of(araddr) == REGION_STATUS) begin
                rdata <= {27'h0, flags};
            end else if (region_of(araddr) == REGION_COMMAND) begin
                rdata <= {16'h0000, command};
            end else if (region_of(araddr) == REGION_MEM) begin
                rdata <= {24'h000000, mem[araddr[5:2]]};
            end else begin
                rresp <= RESP_SLVERR;
            end
        end else begin
            arready <= 1'b1;
        end
    end

endmodule : alu_slice

/* File: design/alu_pkg.sv */
// Constants and carrier types for the add and conjunction datapath slice.
// Assumes an AXI4-Lite master with 8-bit byte addresses and 32-bit data.
package alu_pkg;

    // ****************************************
    // Register map
    // ****************************************
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int MEM_DEPTH = 16;
    localparam logic [7:0] ACC_OFFSET = 8'h00;
    localparam logic [7:0] STATUS_OFFSET = 8'h04;
    localparam logic [7:0] COMMAND_OFFSET = 8'h08;
    localparam logic [7:0] MEM_BASE = 8'h40;
    localparam logic [7:0] MEM_LIMIT = 8'h7c;

    // ****************************************
    // Reset values
    // ****************************************
    localparam logic [7:0] ACC_RESET = 8'h00;
    localparam logic [4:0] FLAGS_RESET = 5'h00;
    localparam logic [15:0] COMMAND_RESET = 16'h0000;
    localparam logic [7:0] MEM_RESET = 8'h00;

    // ****************************************
    // Operation codes
    // ****************************************
    localparam logic [3:0] OP_NONE = 4'h0;
    localparam logic [3:0] OP_ADC_ACC = 4'h1;
    localparam logic [3:0] OP_ADC_MEM = 4'h2;
    localparam logic [3:0] OP_ADD_ACC = 4'h3;
    localparam logic [3:0] OP_ADD_IMM = 4'h4;
    localparam logic [3:0] OP_ADD_MEM = 4'h5;
    localparam logic [3:0] OP_AND_ACC = 4'h6;
    localparam logic [3:0] OP_AND_IMM = 4'h7;
    localparam logic [3:0] OP_AND_MEM = 4'h8;

    // ****************************************
    // Bus answers and address regions
    // ****************************************
    localparam logic [1:0] RESP_OKAY = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;
    localparam logic [2:0] REGION_NONE = 3'h0;
    localparam logic [2:0] REGION_ACC = 3'h1;
    localparam logic [2:0] REGION_STATUS = 3'h2;
    localparam logic [2:0] REGION_COMMAND = 3'h3;
    localparam logic [2:0] REGION_MEM = 3'h4;

    // ****************************************
    // Carrier types
    // ****************************************
    typedef struct packed {
        logic signed_compare_flag;
        logic overflow_flag;
        logic zero_flag;
        logic aux_carry_flag;
        logic carry_flag;
    } flags_type;

    typedef struct packed {
        logic [7:0] imm;
        logic [3:0] addr;
        logic [3:0] op;
    } command_type;

    typedef enum logic [1:0] {
        wr_collect = 2'b01,
        wr_respond = 2'b10
    } wr_state_type;

endpackage : alu_pkg

/* File: design/alu_unit.sv */
// Combinational add and conjunction unit with flag generation.
// Assumes the caller registers its outputs and supplies stable operands.
`timescale 1ns/1ns
module alu_unit
    import alu_pkg::*;
(
    // Operation
    input wire logic [3:0] op,
    input wire logic [7:0] accumulator_reg,
    input wire logic [7:0] mem_byte,
    input wire logic [7:0] imm,
    input wire flags_type flags_in,
    // Result
    output logic [7:0] result,
    output flags_type flags_out,
    output logic to_acc,
    output logic to_mem
);

    // ****************************************
    // Sum with flags
    // ****************************************
    function automatic logic [10:0] add_flags(input logic [7:0] a, input logic [7:0] b,
                                              input logic cin);
        logic [4:0] low;
        logic [8:0] full;
        logic ov;
        low = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, cin};
        full = {1'b0, a} + {1'b0, b} + {8'h00, cin};
        ov = (a[7] == b[7]) && (full[7] != a[7]);
        // Packs carry, aux carry, overflow and the 8-bit sum
        return {full[8], low[4], ov, full[7:0]};
    endfunction : add_flags

    logic [10:0] sum;
    logic [7:0] operand;
    logic cin;
    logic is_add;

    always_comb begin
        operand = (op == OP_ADD_IMM || op == OP_AND_IMM) ? imm : mem_byte; // RULE_04
        cin = (op == OP_ADC_ACC || op == OP_ADC_MEM) ? flags_in.carry_flag : 1'b0; // RULE_01
        is_add = (op == OP_ADC_ACC) || (op == OP_ADC_MEM) || (op == OP_ADD_ACC) ||
                 (op == OP_ADD_IMM) || (op == OP_ADD_MEM);
        sum = add_flags(accumulator_reg, operand, cin);
        flags_out = flags_in; // RULE_10
        to_acc = 1'b0;
        to_mem = 1'b0;
        result = accumulator_reg & operand; // RULE_06 RULE_07 RULE_08
        if (is_add) begin
            result = sum[7:0];
            flags_out.carry_flag = sum[10]; // RULE_09
            flags_out.aux_carry_flag = sum[9]; // RULE_09
            flags_out.overflow_flag = sum[8]; // RULE_09
            // Signed compare is overflow corrected sign
            flags_out.signed_compare_flag = sum[8] ^ sum[7];
        end
        if (op != OP_NONE && op <= OP_AND_MEM) begin
            flags_out.zero_flag = (result == 8'h00); // RULE_09
        end
        case (op)
            OP_ADC_ACC, OP_ADD_ACC, OP_ADD_IMM, OP_AND_ACC, OP_AND_IMM: begin
                to_acc = 1'b1; // RULE_01 RULE_03 RULE_04 RULE_06 RULE_07
            end
            OP_ADC_MEM, OP_ADD_MEM, OP_AND_MEM: begin
                to_mem = 1'b1; // RULE_02 RULE_05 RULE_08 RULE_10
            end
            default: begin
                to_acc = 1'b0;
            end
        endcase
    end

endmodule : alu_unit

/* File: bench/alu_slice_properties.sv */
// Bus timing checks for the datapath slice register port.
// Assumes it is bound to alu_slice and sees only its ports.
`timescale 1ns/1ns
module alu_slice_properties
    import alu_pkg::*;
(
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Write channels
    input wire logic awvalid,
    input wire logic awready,
    input wire logic wvalid,
    input wire logic wready,
    input wire logic bvalid,
    input wire logic [1:0] bresp,
    input wire logic bready,
    // Read channels
    input wire logic arvalid,
    input wire logic [ADDR_W-1:0] araddr,
    input wire logic arready,
    input wire logic rvalid,
    input wire logic [DATA_W-1:0] rdata,
    input wire logic [1:0] rresp,
    input wire logic rready
);
    // ****************************************
    // Properties
    // ****************************************
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    b_hold_a: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
        else $error("write response dropped early");
    b_done_a: assert property (bvalid && bready |=> !bvalid)
        else $error("write response stayed after handshake");
    r_hold_a: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
        else $error("read data dropped or changed early");
    r_answer_a: assert property (arvalid && arready |=> rvalid)
        else $error("read answer late");
    w_answer_a: assert property (awvalid && awready && wvalid && wready
        |=> !bvalid ##1 bvalid) else $error("write answer timing wrong");
    w_block_a: assert property (bvalid |-> !awready && !wready)
        else $error("write taken while response pending");
    r_block_a: assert property (rvalid |-> !arready)
        else $error("read taken while answer pending");
    acc_width_a: assert property (arvalid && arready && araddr[7:2] == 6'h00
        |=> rdata[31:8] == 24'h000000) else $error("accumulator upper bits set");
    flag_width_a: assert property (arvalid && arready && araddr[7:2] == 6'h01
        |=> rdata[31:5] == 27'h0) else $error("status upper bits set");
    hole_error_a: assert property (arvalid && arready && araddr >= 8'h0c
        && araddr < MEM_BASE |=> rresp == RESP_SLVERR) else $error("hole read not refused");
    cover property (bvalid && bready);
    cover property (rvalid && rready && rresp == RESP_SLVERR);
    cover property (awvalid && awready && wvalid && wready);
endmodule : alu_slice_properties

bind alu_slice alu_slice_properties u_alu_slice_properties (.*);

/* File: bench/axi_master.sv */
// Register bus master standing in for the core's decoder side.
// Assumes aclk is free running; requests change only after a rising edge.
`timescale 1ns/1ns
module axi_master
    import alu_pkg::*;
(
    // Clock
    input wire logic aclk,
    // Requests
    output logic awvalid,
    output logic [ADDR_W-1:0] awaddr,
    output logic wvalid,
    output logic [DATA_W-1:0] wdata,
    output logic [3:0] wstrb,
    output logic bready,
    output logic arvalid,
    output logic [ADDR_W-1:0] araddr,
    output logic rready,
    // Answers
    input wire logic awready,
    input wire logic wready,
    input wire logic bvalid,
    input wire logic [1:0] bresp,
    input wire logic arready,
    input wire logic rvalid,
    input wire logic [DATA_W-1:0] rdata,
    input wire logic [1:0] rresp
);
    initial {awvalid, wvalid, bready, arvalid, rready, awaddr, wdata, wstrb, araddr} = '0;

    task wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
            output logic [1:0] r);
        logic ad;
        logic dd;
        ad = 1'b0;
        dd = 1'b0;
        @(posedge aclk);
        awvalid <= 1'b1;
        awaddr <= a;
        wvalid <= 1'b1;
        wdata <= d;
        wstrb <= s;
        while (!(ad && dd)) begin
            @(posedge aclk);
            // Released lines show garbage, not the old value
            if (awvalid && awready) begin
                ad = 1'b1;
                awvalid <= 1'b0;
                awaddr <= ~a;
            end
            if (wvalid && wready) begin
                dd = 1'b1;
                wvalid <= 1'b0;
                wdata <= ~d;
            end
        end
        bready <= 1'b1;
        do @(posedge aclk); while (!bvalid);
        r = bresp;
        bready <= 1'b0;
    endtask : wr

    task rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        @(posedge aclk);
        arvalid <= 1'b1;
        araddr <= a;
        rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (arready) arvalid <= 1'b0;
        end while (!rvalid);
        d = rdata;
        r = rresp;
        rready <= 1'b0;
        araddr <= ~a;
    endtask : rd
endmodule : axi_master

/* File: bench/add_and_alu_ops_tb.sv */
// Self-checking bench for the add and conjunction datapath slice.
// Assumes the bus master model drives every register access.
`timescale 1ns/1ns
module add_and_alu_ops_tb
    import alu_pkg::*;
;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic awvalid, awready, wvalid, wready, bvalid, bready;
    logic arvalid, arready, rvalid, rready;
    logic [ADDR_W-1:0] awaddr, araddr;
    logic [DATA_W-1:0] wdata, rdata;
    logic [3:0] wstrb;
    logic [1:0] bresp, rresp;
    int bad_count = 0;
    int num_checks = 0;

    always #5 aclk = ~aclk;
    alu_slice u_alu_slice (.*, .awprot(3'h0), .arprot(3'h0));
    axi_master u_axi_master (.*);

    // ****************************************
    // Helpers
    // ****************************************
    task chk(input string n, input logic [31:0] e, input logic [31:0] g);
        num_checks++;
        if (g !== e) begin
            bad_count++;
            $display("mismatch %s expected %h seen %h", n, e, g);
        end
    endtask : chk

    task chk_resp(input string n, input logic [1:0] e, input logic [1:0] g);
        num_checks++;
        if (g !== e) begin
            bad_count++;
            $display("mismatch %s expected %h seen %h", n, e, g);
        end
    endtask : chk_resp

    task wr_reg(input logic [7:0] a, input logic [31:0] d);
        logic [1:0] r;
        u_axi_master.wr(a, d, 4'h3, r);
        chk_resp("bresp", RESP_OKAY, r);
    endtask : wr_reg

    task rd_chk(input string n, input logic [7:0] a, input logic [31:0] e);
        logic [31:0] d;
        logic [1:0] r;
        u_axi_master.rd(a, d, r);
        chk(n, e, d);
        chk_resp(n, RESP_OKAY, r);
    endtask : rd_chk

    // Own reference, kept apart from the design's arithmetic
    function automatic void model(input logic [3:0] op, input logic [7:0] a, m, imm,
        input logic [4:0] f, output logic [7:0] ea, em, output logic [4:0] ef);
        logic [7:0] b;
        logic [8:0] s;
        logic [4:0] l;
        logic c;
        logic ov;
        logic [7:0] r;
        b = (op == OP_ADD_IMM || op == OP_AND_IMM) ? imm : m;
        c = (op == OP_ADC_ACC || op == OP_ADC_MEM) ? f[0] : 1'b0;
        s = a + b + c;
        l = a[3:0] + b[3:0] + c;
        ov = (a[7] == b[7]) && (s[7] != a[7]);
        r = (op >= OP_AND_ACC) ? (a & b) : s[7:0];
        ef = {ov ^ s[7], ov, r == 8'h00, l[4], s[8]};
        if (op >= OP_AND_ACC) ef = {f[4:3], r == 8'h00, f[1:0]};
        ea = a;
        em = m;
        if (op == OP_ADC_MEM || op == OP_ADD_MEM || op == OP_AND_MEM) em = r;
        else ea = r;
    endfunction : model

    // Top memory byte used on purpose: index 15 is the map's boundary
    task op_case(input logic [3:0] op, input logic [7:0] a, m, imm, input logic [4:0] f);
        logic [7:0] ea;
        logic [7:0] em;
        logic [4:0] ef;
        model(op, a, m, imm, f, ea, em, ef);
        wr_reg(ACC_OFFSET, {24'h0, a});
        wr_reg(MEM_LIMIT, {24'h0, m});
        wr_reg(STATUS_OFFSET, {27'h0, f});
        wr_reg(COMMAND_OFFSET, {16'h0, imm, 4'hf, op});
        rd_chk("acc", ACC_OFFSET, {24'h0, ea});
        rd_chk("mem", MEM_LIMIT, {24'h0, em});
        rd_chk("flags", STATUS_OFFSET, {27'h0, ef});
    endtask : op_case

    // ****************************************
    // Scenarios
    // ****************************************
    task t_reset();
        rd_chk("acc", ACC_OFFSET, 32'h0);
        rd_chk("flags", STATUS_OFFSET, 32'h0);
        rd_chk("mem", MEM_BASE, 32'h0);
    endtask : t_reset

    task t_add();
        op_case(OP_ADC_ACC, 8'h7f, 8'h00, 8'h00, 5'h01);
        op_case(OP_ADC_MEM, 8'hff, 8'h00, 8'h00, 5'h01);
        op_case(OP_ADD_ACC, 8'h0f, 8'h01, 8'h00, 5'h01);
        op_case(OP_ADD_IMM, 8'h80, 8'h55, 8'h80, 5'h00);
        op_case(OP_ADD_MEM, 8'h90, 8'hf0, 8'h00, 5'h1f);
    endtask : t_add

    task t_and();
        op_case(OP_AND_ACC, 8'hf0, 8'h0f, 8'hff, 5'h1b);
        op_case(OP_AND_IMM, 8'h3c, 8'hff, 8'h24, 5'h1f);
        op_case(OP_AND_MEM, 8'hc3, 8'h81, 8'h00, 5'h0b);
    endtask : t_and

    task t_misc();
        logic [31:0] d;
        logic [1:0] r;
        u_axi_master.wr(8'h20, 32'h5a, 4'h1, r);
        chk_resp("hole bresp", RESP_SLVERR, r);
        u_axi_master.rd(8'h20, d, r);
        chk("hole data", 32'h0, d);
        chk_resp("hole rresp", RESP_SLVERR, r);
        wr_reg(ACC_OFFSET, 32'h5a);
        wr_reg(COMMAND_OFFSET, 32'h0009);
        rd_chk("acc", ACC_OFFSET, 32'h5a);
        rd_chk("cmd", COMMAND_OFFSET, 32'h9);
        u_axi_master.wr(ACC_OFFSET, 32'hff, 4'h2, r);
        chk_resp("lane bresp", RESP_OKAY, r);
        rd_chk("acc lane", ACC_OFFSET, 32'h5a);
    endtask : t_misc

    task print_verdict();
        $display("checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask : print_verdict

    initial begin
        repeat (6) @(posedge aclk);
        aresetn <= 1'b1;
        t_reset();
        t_add();
        t_and();
        t_misc();
        print_verdict();
    end

    // A hung handshake ends here
    initial begin
        #100000;
        bad_count++;
        print_verdict();
    end
endmodule : add_and_alu_ops_tb
